// *** shared/link_tx_pkg.sv ***
// Purpose: Constants shared by the transmit data-link status and data-entry block.
// Assumes: 8-bit register port, one clock at 125 MHz.
// Notes: Offsets are the printed register indices.
package link_tx_pkg;
    // ==========================================================
    // Register map
    localparam logic [7:0] STATUS_OFS = 8'hAC;
    localparam logic [7:0] DATA_OFS = 8'hAD;
    localparam logic [7:0] CFG_OFS = 8'hA8;
    localparam logic [7:0] START_THR_OFS = 8'hA9;
    localparam logic [7:0] LOW_THR_OFS = 8'hAA;
    localparam logic [7:0] IEN_OFS = 8'hAB;
    // ==========================================================
    // Field positions
    localparam int LOW_FILL_BIT = 0;
    localparam int UNDERRUN_BIT = 1;
    localparam int OVERRUN_BIT = 2;
    localparam int FULL_EV_BIT = 3;
    localparam int REPORT_BIT = 4;
    localparam int BELOW_LOW_BIT = 5;
    localparam int FULL_LIVE_BIT = 6;
    localparam int CFG_EN_BIT = 0;
    localparam int CFG_END_MSG_BIT = 3;
    localparam int CFG_PREN_BIT = 5;
    localparam int CFG_FIFOCLR_BIT = 6;
    // ==========================================================
    // Reset values and sizes
    localparam logic [7:0] CFG_RST = 8'h82;
    localparam logic [6:0] START_THR_RST = 7'h40;
    localparam logic [6:0] LOW_THR_RST = 7'h07;
    localparam logic [4:0] IEN_RST = 5'h00;
    localparam int FIFO_DEPTH = 128;
    localparam int CNT_W = 8;
    // ==========================================================
    // Transmit bit rate: one bit per BIT_DIV clocks
    localparam int BIT_DIV = 81;
    typedef enum logic [1:0] {
        TX_IDLE = 2'b00,
        TX_SEND = 2'b01,
        TX_DRAIN = 2'b11
    } tx_state_e;
endpackage : link_tx_pkg

// *** hw/link_tx_byte_store.sv ***
// Purpose: 128-byte store for transmit bytes with occupancy count.
// Assumes: Push is refused while full; pop only while not empty.
// Notes: Clear empties the store at once.
module link_tx_byte_store
    import link_tx_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_clear,
    input wire logic i_push,
    input wire logic [7:0] i_data,
    input wire logic i_pop,
    output logic [7:0] o_data,
    output logic [CNT_W-1:0] o_count
);
    logic [7:0] mem [FIFO_DEPTH];
    logic [6:0] wr_q;
    logic [6:0] rd_q;
    logic [CNT_W-1:0] cnt_q;
    logic do_push;
    logic do_pop;

    assign do_push = i_push && (cnt_q != CNT_W'(FIFO_DEPTH));
    assign do_pop = i_pop && (cnt_q != '0);
    assign o_data = mem[rd_q];
    assign o_count = cnt_q;

    always_ff @(posedge i_clk) begin
        if (do_push) begin
            mem[wr_q] <= i_data;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst || i_clear) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            if (do_push) begin
                wr_q <= wr_q + 7'd1;
            end
            if (do_pop) begin
                rd_q <= rd_q + 7'd1;
            end
            if (do_push && !do_pop) begin
                cnt_q <= cnt_q + CNT_W'(1);
            end else if (do_pop && !do_push) begin
                cnt_q <= cnt_q - CNT_W'(1);
            end
        end
    end
endmodule : link_tx_byte_store

// *** hw/link_tx_bit_tick.sv ***
// Purpose: Divider giving a one-cycle bit-rate enable.
// Assumes: Single clock.
// Notes: Period is the package bit divisor.
module link_tx_bit_tick
    import link_tx_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst,
    output logic o_tick
);
    logic [6:0] cnt_q;

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            cnt_q <= '0;
            o_tick <= 1'b0;
        end else if (cnt_q == 7'(BIT_DIV - 1)) begin
            cnt_q <= '0;
            o_tick <= 1'b1;
        end else begin
            cnt_q <= cnt_q + 7'd1;
            o_tick <= 1'b0;
        end
    end
endmodule : link_tx_bit_tick

// *** hw/link_tx_controller.sv ***
// Purpose: Status, interrupt and byte-entry part of a transmit data-link controller.
// Assumes: Host keeps register accesses no faster than the transmit bit rate.
// Notes: Framing, stuffing and checksum are outside; bytes leave LSB first.
module link_tx_controller
    import link_tx_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    input wire logic i_report_req,
    output logic o_tx_bit,
    output logic o_tx_valid,
    output logic o_end_of_message,
    output logic o_irq_out_n
);
    // ==========================================================
    // Registers
    logic [7:0] cfg_q;
    logic [6:0] start_tx_threshold_q;
    logic [6:0] low_irq_threshold_q;
    logic [4:0] irq_en_q;
    logic [4:0] flags_q;
    logic [4:0] flags_d;
    logic [7:0] last_byte_q;
    logic below_low_q;
    logic full_q;
    logic report_q;

    logic wr_status;
    logic rd_status;
    logic wr_data;
    logic [CNT_W-1:0] fill;
    logic below_low_level;
    logic full_now;
    logic [7:0] fifo_out;
    logic pop;
    logic bit_tick;

    assign wr_status = i_wr && (i_addr == STATUS_OFS);
    assign rd_status = i_rd && (i_addr == STATUS_OFS);
    assign wr_data = i_wr && (i_addr == DATA_OFS);

    assign full_now = (fill == CNT_W'(FIFO_DEPTH));
    assign below_low_level = (fill == '0) ||
        (fill < {1'b0, low_irq_threshold_q});

    // ==========================================================
    // Submodules
    link_tx_byte_store u_store (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_clear(cfg_q[CFG_FIFOCLR_BIT]),
        .i_push(wr_data),
        .i_data(i_wdata),
        .i_pop(pop),
        .o_data(fifo_out),
        .o_count(fill)
    );

    link_tx_bit_tick u_tick (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .o_tick(bit_tick)
    );

    // ==========================================================
    // Configuration writes
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            cfg_q <= CFG_RST;
        end else if (i_wr && i_addr == CFG_OFS) begin
            cfg_q <= i_wdata;
        end else if (wr_data) begin
            cfg_q[CFG_END_MSG_BIT] <= 1'b0;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            start_tx_threshold_q <= START_THR_RST;
            low_irq_threshold_q <= LOW_THR_RST;
            irq_en_q <= IEN_RST;
            last_byte_q <= '0;
        end else if (i_wr) begin
            if (i_addr == START_THR_OFS) begin
                start_tx_threshold_q <= i_wdata[6:0];
            end
            if (i_addr == LOW_THR_OFS) begin
                low_irq_threshold_q <= i_wdata[6:0];
            end
            if (i_addr == IEN_OFS) begin
                irq_en_q <= i_wdata[4:0];
            end
            if (i_addr == DATA_OFS) begin
                last_byte_q <= i_wdata;
            end
        end
    end

    assign o_end_of_message = cfg_q[CFG_END_MSG_BIT];

    // ==========================================================
    // Serializer
    tx_state_e state_q;
    logic [7:0] shift_q;
    logic [2:0] bit_q;
    logic in_packet_q;
    logic underrun_ev;
    logic start_ok;

    assign start_ok = fill > {1'b0, start_tx_threshold_q};
    assign pop = bit_tick && (state_q != TX_SEND || bit_q == 3'd7) &&
        cfg_q[CFG_EN_BIT] && fill != '0 &&
        (state_q != TX_IDLE || start_ok);
    assign underrun_ev = bit_tick && in_packet_q && fill == '0 &&
        (state_q == TX_DRAIN || (state_q == TX_SEND && bit_q == 3'd7));

    always_ff @(posedge i_clk) begin
        if (i_rst || cfg_q[CFG_FIFOCLR_BIT] || !cfg_q[CFG_EN_BIT]) begin
            state_q <= TX_IDLE;
            shift_q <= '0;
            bit_q <= '0;
            o_tx_bit <= 1'b1;
            o_tx_valid <= 1'b0;
        end else if (bit_tick) begin
            case (state_q)
                TX_IDLE: begin
                    o_tx_valid <= 1'b0;
                    o_tx_bit <= 1'b1;
                    if (pop) begin
                        shift_q <= fifo_out;
                        bit_q <= '0;
                        state_q <= TX_SEND;
                    end
                end
                TX_SEND: begin
                    o_tx_bit <= shift_q[0];
                    o_tx_valid <= 1'b1;
                    shift_q <= {1'b0, shift_q[7:1]};
                    if (bit_q == 3'd7) begin
                        bit_q <= '0;
                        if (pop) begin
                            shift_q <= fifo_out;
                        end else begin
                            state_q <= TX_DRAIN;
                        end
                    end else begin
                        bit_q <= bit_q + 3'd1;
                    end
                end
                TX_DRAIN: begin
                    o_tx_valid <= 1'b0;
                    o_tx_bit <= 1'b1;
                    if (pop) begin
                        shift_q <= fifo_out;
                        state_q <= TX_SEND;
                    end else if (!in_packet_q) begin
                        state_q <= TX_IDLE;
                    end
                end
                default: begin
                    state_q <= TX_IDLE;
                end
            endcase
        end
    end

    // Packet is open from the first byte until a configuration write sets end-of-message, an underrun or a FIFO clear
    always_ff @(posedge i_clk) begin
        if (i_rst || cfg_q[CFG_FIFOCLR_BIT]) begin
            in_packet_q <= 1'b0;
        end else if (i_wr && i_addr == CFG_OFS && i_wdata[CFG_END_MSG_BIT]) begin
            in_packet_q <= 1'b0;
        end else if (wr_data) begin
            in_packet_q <= 1'b1;
        end else if (underrun_ev) begin
            in_packet_q <= 1'b0;
        end
    end

    // ==========================================================
    // Event flags
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            below_low_q <= 1'b1;
            full_q <= 1'b0;
            report_q <= 1'b0;
        end else begin
            below_low_q <= below_low_level;
            full_q <= full_now;
            report_q <= i_report_req && cfg_q[CFG_PREN_BIT];
        end
    end

    always_comb begin
        flags_d = flags_q;
        if (rd_status) begin
            flags_d = '0;
        end
        if (wr_status) begin
            flags_d[UNDERRUN_BIT] = 1'b0;
        end
        // Sets come last so an event in a clearing cycle survives
        if (below_low_level && !below_low_q) begin
            flags_d[LOW_FILL_BIT] = 1'b1;
        end
        if (underrun_ev) begin
            flags_d[UNDERRUN_BIT] = 1'b1;
        end
        if (wr_data && full_now) begin
            flags_d[OVERRUN_BIT] = 1'b1;
        end
        if (full_now && !full_q) begin
            flags_d[FULL_EV_BIT] = 1'b1;
        end
        if (i_report_req && cfg_q[CFG_PREN_BIT] && !report_q) begin
            flags_d[REPORT_BIT] = 1'b1;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            flags_q <= '0;
        end else begin
            flags_q <= flags_d;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_irq_out_n <= 1'b1;
        end else begin
            o_irq_out_n <= ~|(flags_d & irq_en_q);
        end
    end

    // ==========================================================
    // Read port
    logic [7:0] status_word;
    logic [7:0] rd_word;

    // Live bits sit above the sticky flags; bit 7 reads as zero
    assign status_word = {1'b0, full_now, below_low_level, flags_q};

    always_comb begin
        rd_word = '0;
        case (i_addr)
            CFG_OFS: begin
                rd_word = cfg_q;
            end
            START_THR_OFS: begin
                rd_word = {1'b0, start_tx_threshold_q};
            end
            LOW_THR_OFS: begin
                rd_word = {1'b0, low_irq_threshold_q};
            end
            IEN_OFS: begin
                rd_word = {3'b000, irq_en_q};
            end
            STATUS_OFS: begin
                rd_word = status_word;
            end
            DATA_OFS: begin
                rd_word = last_byte_q;
            end
            default: begin
                rd_word = '0;
            end
        endcase
    end

    // Data stand for one cycle after the strobe and read as zero otherwise
    always_ff @(posedge i_clk) begin
        if (i_rst || !i_rd) begin
            o_rdata <= '0;
        end else begin
            o_rdata <= rd_word;
        end
    end
endmodule : link_tx_controller

// *** bench/link_tx_controller_chk.sv ***
// Purpose: Port-level assertions for the transmit data-link controller.
// Assumes: Single clock, synchronous active-high reset.
// Notes: Enable and report-enable bits are shadowed from register writes.
module link_tx_controller_chk
    import link_tx_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [7:0] o_rdata,
    input wire logic i_report_req,
    input wire logic o_tx_bit,
    input wire logic o_tx_valid,
    input wire logic o_end_of_message,
    input wire logic o_irq_out_n
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================================
    // Helper state
    logic [4:0] en_q;
    logic pren_q;
    logic run_q;
    int cnt_q;
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            en_q <= IEN_RST;
            pren_q <= CFG_RST[CFG_PREN_BIT];
            run_q <= 1'b0;
        end else if (i_wr && i_addr == IEN_OFS) begin
            en_q <= i_wdata[4:0];
        end else if (i_wr && i_addr == CFG_OFS) begin
            pren_q <= i_wdata[CFG_PREN_BIT];
            run_q <= i_wdata[CFG_EN_BIT] && !i_wdata[CFG_FIFOCLR_BIT];
        end
    end
    // Cycles into the current bit while valid
    always_ff @(posedge i_clk) begin
        if (i_rst || !o_tx_valid) begin
            cnt_q <= 0;
        end else begin
            cnt_q <= (cnt_q == BIT_DIV - 1) ? 0 : cnt_q + 1;
        end
    end
    // ==========================================================
    // Assertions
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);
    chk_msg_end_clear: assert property (
        i_wr && i_addr == DATA_OFS |=> !o_end_of_message)
        else $error("end of message not cleared");
    chk_msg_end_stable: assert property (
        !(i_wr && (i_addr == CFG_OFS || i_addr == DATA_OFS)) |=> $stable(o_end_of_message))
        else $error("end of message changed unprompted");
    chk_irq_masked: assert property (
        en_q == 5'h00 [*3] |-> o_irq_out_n) else $error("irq with all masked");
    chk_report_irq: assert property (
        $rose(i_report_req) && pren_q && en_q[REPORT_BIT] |-> ##[1:3] !o_irq_out_n)
        else $error("report irq missing");
    chk_read_release: assert property (
        (i_rd && i_addr == STATUS_OFS && en_q == 5'h08 && !i_wr)
        ##1 (!i_wr && en_q == 5'h08) [*2] |-> ##1 o_irq_out_n) else $error("irq kept");
    chk_bit_hold: assert property (
        o_tx_valid && cnt_q != 0 |-> $stable(o_tx_bit)) else $error("bit changed early");
    chk_bit_whole: assert property (
        $fell(o_tx_valid) && run_q |-> $past(cnt_q) == BIT_DIV - 1) else $error("bit cut short");
    chk_tx_idle: assert property (
        !o_tx_valid |-> o_tx_bit) else $error("idle line not high");
    chk_status_top: assert property (
        i_rd && i_addr == STATUS_OFS |=> !o_rdata[7]) else $error("status bit 7 set");
    cover property ($fell(o_tx_valid));
    cover property (!o_irq_out_n);
    cover property (i_rd && i_addr == STATUS_OFS);
endmodule : link_tx_controller_chk

// *** bench/link_rx_model.sv ***
// Purpose: Data-link receiver standing in for the transmit framer.
// Assumes: Bits are valid for BIT_DIV clocks each, LSB first.
// Notes: Sampled mid-bit; received bytes kept in got.
module link_rx_model
    import link_tx_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_bit,
    input wire logic i_valid,
    output int o_count
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] got [0:7];
    logic [7:0] sh_q;
    int cyc_q;
    int nb_q;
    always_ff @(posedge i_clk) begin
        if (i_rst || !i_valid) begin
            cyc_q <= 0;
        end else begin
            cyc_q <= (cyc_q == BIT_DIV - 1) ? 0 : cyc_q + 1;
        end
    end
    // Shift in LSB first, store a byte every eight bits
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_count <= 0;
            nb_q <= 0;
        end else if (i_valid && cyc_q == BIT_DIV / 2) begin
            sh_q <= {i_bit, sh_q[7:1]};
            nb_q <= (nb_q == 7) ? 0 : nb_q + 1;
            if (nb_q == 7) begin
                got[o_count[2:0]] <= {i_bit, sh_q[7:1]};
                o_count <= o_count + 1;
            end
        end
    end
endmodule : link_rx_model

// *** bench/tb_top.sv ***
// Purpose: Self-checking bench for the transmit data-link controller.
// Assumes: Accesses spaced one bit period apart.
// Notes: Random bytes from a fixed seed.
module tb_top
    import link_tx_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_clk = 0;
    logic i_rst = 1;
    logic i_wr = 0;
    logic i_rd = 0;
    logic i_report_req = 0;
    logic [7:0] i_addr = 8'h00;
    logic [7:0] i_wdata = 8'h00;
    logic [7:0] o_rdata;
    logic o_tx_bit, o_tx_valid, o_end_of_message, o_irq_out_n;
    logic [7:0] rd_v;
    logic [7:0] exp_b [0:2];
    int rx_cnt;
    int miscompares = 0;
    int checks_done = 0;
    always #4 i_clk = ~i_clk;
    link_tx_controller link_tx_controller_i (.i_clk, .i_rst, .i_addr, .i_wdata, .i_wr,
        .i_rd, .o_rdata, .i_report_req, .o_tx_bit, .o_tx_valid, .o_end_of_message,
        .o_irq_out_n);
    link_rx_model link_rx_model_i (.i_clk, .i_rst, .i_bit(o_tx_bit), .i_valid(o_tx_valid),
        .o_count(rx_cnt));
    // ==========================================================
    // Bus tasks and checks
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clk);
        i_wr <= 1'b0;
        repeat (BIT_DIV) @(posedge i_clk);
        #1;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge i_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1 d = o_rdata;
        repeat (BIT_DIV) @(posedge i_clk);
        #1;
    endtask : rd
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        checks_done++;
        if (g !== e) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk
    task automatic chk_bit(input logic g, input logic e);
        chk({7'h00, g}, {7'h00, e});
    endtask : chk_bit
    // Status word from the live bits and the sticky flags
    function automatic logic [7:0] status_exp(input logic full, input logic below,
        input logic [4:0] flags);
        logic [7:0] s;
        s = {3'b000, flags};
        s[FULL_LIVE_BIT] = full;
        s[BELOW_LOW_BIT] = below;
        return s;
    endfunction : status_exp
    task automatic finish_test();
        if (miscompares == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : finish_test
    // ==========================================================
    // Main sequence
    initial begin
        int n;
        void'($urandom(36455));
        repeat (12) @(posedge i_clk);
        i_rst <= 1'b0;
        #1 chk_bit(o_irq_out_n, 1'b1);
        rd(8'hB0, rd_v);
        chk(rd_v, 8'h00);
        rd(STATUS_OFS, rd_v);
        chk(rd_v & 8'h60, 8'h20);
        wr(CFG_OFS, 8'h42);
        wr(CFG_OFS, 8'h02);
        rd(STATUS_OFS, rd_v);
        for (n = 0; n < FIFO_DEPTH; n++) wr(DATA_OFS, 8'($urandom));
        chk_bit(o_irq_out_n, 1'b1);
        wr(IEN_OFS, 8'h08);
        chk_bit(o_irq_out_n, 1'b0);
        wr(DATA_OFS, 8'hA5);
        rd(STATUS_OFS, rd_v);
        chk(rd_v, status_exp(1'b1, 1'b0, 5'h0C));
        chk_bit(o_irq_out_n, 1'b1);
        rd(STATUS_OFS, rd_v);
        chk(rd_v, status_exp(1'b1, 1'b0, 5'h00));
        wr(CFG_OFS, 8'h42);
        wr(LOW_THR_OFS, 8'h01);
        wr(START_THR_OFS, 8'h02);
        wr(IEN_OFS, 8'h02);
        wr(CFG_OFS, 8'h03);
        rd(STATUS_OFS, rd_v);
        for (n = 0; n < 3; n++) begin
            exp_b[n] = 8'($urandom);
            wr(DATA_OFS, exp_b[n]);
            if (n == 1) chk_bit(o_tx_valid, 1'b0);
        end
        n = 0;
        while (rx_cnt < 3 && n < 5000) begin
            @(posedge i_clk);
            n++;
        end
        if (n == 5000) begin
            miscompares++;
        end
        for (n = 0; n < 3; n++) chk(link_rx_model_i.got[n], exp_b[n]);
        repeat (4 * 8 * BIT_DIV) @(posedge i_clk);
        #1 chk_bit(o_irq_out_n, 1'b0);
        wr(CFG_OFS, 8'h0B);
        chk_bit(o_end_of_message, 1'b1);
        wr(STATUS_OFS, 8'h00);
        chk_bit(o_irq_out_n, 1'b1);
        rd(STATUS_OFS, rd_v);
        chk(rd_v & 8'h23, 8'h21);
        wr(DATA_OFS, 8'h3C);
        chk_bit(o_end_of_message, 1'b0);
        wr(CFG_OFS, 8'h20);
        wr(IEN_OFS, 8'h10);
        @(posedge i_clk);
        i_report_req <= 1'b1;
        repeat (4) @(posedge i_clk);
        #1 chk_bit(o_irq_out_n, 1'b0);
        rd(STATUS_OFS, rd_v);
        chk(rd_v & 8'h10, 8'h10);
        chk_bit(o_irq_out_n, 1'b1);
        @(posedge i_clk);
        i_report_req <= 1'b0;
        finish_test();
    end
endmodule : tb_top
bind link_tx_controller link_tx_controller_chk chk_i (.i_clk, .i_rst, .i_addr, .i_wdata,
    .i_wr, .i_rd, .o_rdata, .i_report_req, .o_tx_bit, .o_tx_valid, .o_end_of_message,
    .o_irq_out_n);
